// file: bpc_defs.vh
// Purpose: Shared constants of the block
// Assumes: Included by bare name; definitions only
// Notes: Decimal figures as sized hex
`ifndef BPC_DEFS_VH
`define BPC_DEFS_VH

// Block word offsets
`define BPC_W_SEQ 6'h00
`define BPC_W_ID 6'h01
`define BPC_W_ARG1 6'h02
`define BPC_W_CNT 6'h02
// Command control ID bases (5000, 5100), max count
`define BPC_CC_P1_BASE 16'h1388
`define BPC_CC_P2_BASE 16'h13ec
`define BPC_CC_MAX_N 16'h0006
// Warm boot 9998, cold boot 9999
`define BPC_ID_WARM 16'h270e
`define BPC_ID_COLD 16'h270f
// Highest legal command index, 99
`define BPC_IDX_MAX 16'h0063
// Port type codes
`define BPC_TYPE_MASTER 3'h0
`define BPC_TYPE_SLAVE 3'h1
`define BPC_TYPE_PT 3'h4
`define BPC_TYPE_PT_SWAP 3'h5
// Modbus functions and limits (125 words, 800 coils)
`define BPC_FN_WR_SINGLE 8'h06
`define BPC_FN_WR_MULTI 8'h10
`define BPC_FN_WR_COILS 8'h0f
`define BPC_MAX_REGS 11'h07d
`define BPC_MAX_COILS 11'h320
// Holding register base, 40001
`define BPC_HREG_BASE 17'h09c41
// Exception codes
`define BPC_EXC_NONE 8'h00
`define BPC_EXC_FUNC 8'h01
`define BPC_EXC_ADDR 8'h02
`define BPC_EXC_VALUE 8'h03
`define BPC_EXC_BUSY 8'h06

`endif

// file: bpc_top.v
// Purpose: Command control, boot blocks and direct pass-thru writes
// Assumes: One clock; inputs come from logic on that clock
// Notes: Pass-thru writes of both ports share one FIFO toward the backplane
//
// Overview of operation
// - Seq change starts; answer seq+1
// - Request: seq, ID, 62 words
// - Response: seq, ID, 62 words
// - IDs 5001-5006 port 1, 5101-5106 port 2
// - Last ID digit is index count
// - Index 0-99 queues that command
// - Word 1 ID, word 2 count
// - ID 9998 requests warm reset
// - ID 9999 requests cold reset
// - Port type 0,1,4,5 selects mode
// - Pass-thru takes functions 6, 16
// - Coil writes limited to 800 bits (here over 800 answers exception 3, any other coil write exception 1)
// - Bad address answers exception 2
// - Answer only after data queued
// - Full queue discards data, answers busy (here only if full when the path is granted; later words wait)
// - Address plus 40001
// - Swap mode exchanges word bytes
// - Pass-thru bypasses internal database
// - Both ports pass-thru at once
// - Block pass-thru: count, address, data (not implemented here; only direct port writes)
`include "bpc_defs.vh"
`timescale 1ns/1ps
`default_nettype none

// Synchronous FIFO, valid/ready both sides
module bpc_fifo #(
    parameter WIDTH = 33,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire core_clk,
    input wire rst,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage, no reset needed
    reg [AW-1:0] wptr_q; // Write index
    reg [AW-1:0] rptr_q; // Read index
    reg [AW:0] cnt_q; // Fill level
    wire push;
    wire pop;

    assign in_ready = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign out_data = mem[rptr_q];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // No reset, so it maps to RAM
    always @(posedge core_clk)
    begin
        if (push)
        begin
            mem[wptr_q] <= in_data;
        end
    end

    // Pointers and level
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            wptr_q <= {AW{1'b0}};
            rptr_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
            begin
                wptr_q <= (wptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wptr_q + 1'b1;
            end
            if (pop)
            begin
                rptr_q <= (rptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rptr_q + 1'b1;
            end
            if (push & ~pop)
            begin
                cnt_q <= cnt_q + 1'b1;
            end
            else if (pop & ~push)
            begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule // bpc_fifo

// One Modbus slave port in direct pass-thru mode
module bpc_pt_port #(
    parameter [16:0] HREG_WORDS = 17'h02710
) (
    input wire core_clk,
    input wire rst,
    input wire [2:0] mode,
    input wire hdr_valid,
    output reg hdr_ready_q,
    input wire [7:0] func,
    input wire [15:0] addr,
    input wire [10:0] count,
    input wire wd_valid,
    output reg wd_ready_q,
    input wire [15:0] wd,
    output reg rsp_valid_q,
    output reg [7:0] rsp_exc_q,
    output wire lock_req,
    input wire grant,
    output wire push_valid,
    output wire [32:0] push_data,
    input wire push_ready
);
    localparam [3:0] S_IDLE = 4'b0001; // Waiting for a header
    localparam [3:0] S_ARB = 4'b0010; // Waiting for the shared path
    localparam [3:0] S_DATA = 4'b0100; // Moving or dropping words
    localparam [3:0] S_RSP = 4'b1000; // One-cycle answer
    reg [3:0] st_q;
    reg [3:0] st_d;
    reg keep_q; // Words go to the FIFO, not dropped
    reg swap_q; // Byte swap latched per request
    reg [10:0] left_q; // Words still to take
    reg [16:0] dst_q; // Next processor address
    reg hold_v_q; // One-word holding stage
    reg [15:0] hold_q;
    reg [7:0] exc_d;
    wire pt_mode;
    wire take_hdr;
    wire take_wd;
    wire push;
    wire hold_v_d;
    wire [10:0] words;
    wire [16:0] span;

    assign pt_mode = (mode == `BPC_TYPE_PT) || (mode == `BPC_TYPE_PT_SWAP);
    assign take_hdr = hdr_valid & hdr_ready_q;
    assign take_wd = wd_valid & wd_ready_q;
    assign words = (func == `BPC_FN_WR_SINGLE) ? 11'h001 : count;
    assign span = {1'b0, addr} + {6'h00, words};
    // Sole write path; no database
    assign push_valid = hold_v_q & keep_q & grant;
    assign push = push_valid & push_ready;
    assign push_data = {dst_q, hold_q};
    assign lock_req = st_q[2] | st_q[1];
    assign hold_v_d = take_wd | (hold_v_q & ~push & keep_q);

    // Header checks in priority order
    always @*
    begin
        exc_d = `BPC_EXC_NONE;
        if ((func == `BPC_FN_WR_COILS) && (count > `BPC_MAX_COILS))
        begin
            exc_d = `BPC_EXC_VALUE;
        end
        else if ((func != `BPC_FN_WR_SINGLE) && (func != `BPC_FN_WR_MULTI))
        begin
            exc_d = `BPC_EXC_FUNC;
        end
        else if ((words == 11'h000) || (words > `BPC_MAX_REGS))
        begin
            exc_d = `BPC_EXC_VALUE;
        end
        else if (span > HREG_WORDS)
        begin
            exc_d = `BPC_EXC_ADDR;
        end
    end

    // Next state
    always @*
    begin
        st_d = st_q;
        case (st_q)
            S_IDLE:
            begin
                if (take_hdr)
                begin
                    st_d = (exc_d == `BPC_EXC_NONE) ? S_ARB : S_RSP;
                end
            end
            S_ARB:
            begin
                if (grant)
                begin
                    st_d = S_DATA;
                end
            end
            S_DATA:
            begin
                // Answer once last word is in FIFO or dropped
                if ((left_q == 11'h000) && !hold_v_q)
                begin
                    st_d = S_RSP;
                end
            end
            S_RSP:
            begin
                st_d = S_IDLE;
            end
            default:
            begin
                st_d = S_IDLE;
            end
        endcase
    end

    // Datapath and registered outputs
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            st_q <= S_IDLE;
            hdr_ready_q <= 1'b0;
            wd_ready_q <= 1'b0;
            rsp_valid_q <= 1'b0;
            rsp_exc_q <= 8'h00;
            keep_q <= 1'b0;
            swap_q <= 1'b0;
            left_q <= 11'h000;
            dst_q <= 17'h00000;
            hold_v_q <= 1'b0;
            hold_q <= 16'h0000;
        end
        else
        begin
            st_q <= st_d;
            hdr_ready_q <= (st_d == S_IDLE) & pt_mode & ~take_hdr;
            rsp_valid_q <= (st_d == S_RSP);
            // Take a word only into an empty stage
            wd_ready_q <= (st_d == S_DATA) && !hold_v_d && (left_q - {10'h000, take_wd} != 11'h000);
            if (take_hdr)
            begin
                rsp_exc_q <= exc_d;
                left_q <= words;
                swap_q <= (mode == `BPC_TYPE_PT_SWAP);
                dst_q <= `BPC_HREG_BASE + {1'b0, addr};
            end
            if ((st_q == S_ARB) && grant)
            begin
                // Full at arrival: drop, busy
                keep_q <= push_ready;
                if (!push_ready)
                begin
                    rsp_exc_q <= `BPC_EXC_BUSY;
                end
            end
            if (take_wd)
            begin
                left_q <= left_q - 1'b1;
                hold_q <= swap_q ? {wd[7:0], wd[15:8]} : wd;
            end
            hold_v_q <= hold_v_d;
            if (push)
            begin
                dst_q <= dst_q + 1'b1;
            end
            if (st_q == S_RSP)
            begin
                keep_q <= 1'b0;
            end
        end
    end
endmodule // bpc_pt_port

// Top: command control interpreter plus two pass-thru ports
module bpc_top #(
    parameter [16:0] HREG_WORDS = 17'h02710,
    parameter FIFO_DEPTH = 8
) (
    input wire core_clk,
    input wire rst,
    input wire [15:0] out_seq,
    input wire [15:0] req_id,
    output reg [5:0] req_rd_addr_q,
    input wire [15:0] req_rd_data,
    output reg [15:0] in_seq_q,
    output reg rsp_we_q,
    output reg [5:0] rsp_addr_q,
    output reg [15:0] rsp_data_q,
    output reg cmdq_push_q,
    output reg cmdq_port_q,
    output reg [6:0] cmdq_index_q,
    input wire cmdq_full_p1,
    input wire cmdq_full_p2,
    output reg warm_boot_q,
    output reg cold_boot_q,
    input wire [2:0] p1_type,
    input wire p1_hdr_valid,
    output wire p1_hdr_ready_q,
    input wire [7:0] p1_func,
    input wire [15:0] p1_addr,
    input wire [10:0] p1_count,
    input wire p1_wd_valid,
    output wire p1_wd_ready_q,
    input wire [15:0] p1_wd,
    output wire p1_rsp_valid_q,
    output wire [7:0] p1_rsp_exc_q,
    input wire [2:0] p2_type,
    input wire p2_hdr_valid,
    output wire p2_hdr_ready_q,
    input wire [7:0] p2_func,
    input wire [15:0] p2_addr,
    input wire [10:0] p2_count,
    input wire p2_wd_valid,
    output wire p2_wd_ready_q,
    input wire [15:0] p2_wd,
    output wire p2_rsp_valid_q,
    output wire [7:0] p2_rsp_exc_q,
    output reg bp_we_q,
    output reg [16:0] bp_addr_q,
    output reg [15:0] bp_data_q,
    input wire bp_ready
);
    localparam [5:0] C_IDLE = 6'b000001; // Watching the sequence word
    localparam [5:0] C_RD = 6'b000010; // Index address issued
    localparam [5:0] C_CHK = 6'b000100; // Index word present
    localparam [5:0] C_W1 = 6'b001000; // Writing block ID
    localparam [5:0] C_W2 = 6'b010000; // Writing count
    localparam [5:0] C_SEQ = 6'b100000; // Publishing the sequence
    reg [5:0] cs_q;
    reg [15:0] last_seq_q; // Sequence seen last
    reg [15:0] id_q; // Block being served
    reg [2:0] n_q; // Indexes in this block
    reg [2:0] i_q; // Index being read
    reg [2:0] added_q; // Commands queued
    reg port_q; // 0 = port 1, 1 = port 2
    reg boot_q; // Block is a boot request
    reg [1:0] owner_q; // Pass-thru path owner, one-hot
    wire [15:0] off1;
    wire [15:0] off2;
    wire is_p1;
    wire is_p2;
    wire is_boot;
    wire port_full;
    wire [1:0] lock;
    wire [1:0] pvalid;
    wire [32:0] pdata1;
    wire [32:0] pdata2;
    wire fifo_in_valid;
    wire fifo_in_ready;
    wire [32:0] fifo_in_data;
    wire fifo_out_valid;
    wire fifo_out_ready;
    wire [32:0] fifo_out_data;

    assign off1 = req_id - `BPC_CC_P1_BASE;
    assign off2 = req_id - `BPC_CC_P2_BASE;
    assign is_p1 = (off1 != 16'h0000) && (off1 <= `BPC_CC_MAX_N);
    assign is_p2 = (off2 != 16'h0000) && (off2 <= `BPC_CC_MAX_N);
    assign is_boot = (req_id == `BPC_ID_WARM) || (req_id == `BPC_ID_COLD);
    assign port_full = port_q ? cmdq_full_p2 : cmdq_full_p1;

    // Command control, warm and cold boot interpreter
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            cs_q <= C_IDLE;
            last_seq_q <= 16'h0000;
            in_seq_q <= 16'h0000;
            id_q <= 16'h0000;
            n_q <= 3'h0;
            i_q <= 3'h0;
            added_q <= 3'h0;
            port_q <= 1'b0;
            boot_q <= 1'b0;
            req_rd_addr_q <= 6'h00;
            rsp_we_q <= 1'b0;
            rsp_addr_q <= 6'h00;
            rsp_data_q <= 16'h0000;
            cmdq_push_q <= 1'b0;
            cmdq_port_q <= 1'b0;
            cmdq_index_q <= 7'h00;
            warm_boot_q <= 1'b0;
            cold_boot_q <= 1'b0;
        end
        else
        begin
            rsp_we_q <= 1'b0;
            cmdq_push_q <= 1'b0;
            warm_boot_q <= 1'b0;
            cold_boot_q <= 1'b0;
            case (cs_q)
                C_IDLE:
                begin
                    // Area complete once seq moves
                    if (out_seq != last_seq_q)
                    begin
                        last_seq_q <= out_seq;
                        id_q <= req_id;
                        port_q <= is_p2;
                        boot_q <= is_boot;
                        added_q <= 3'h0;
                        i_q <= 3'h1;
                        req_rd_addr_q <= `BPC_W_ARG1;
                        // Unknown IDs are consumed silently
                        if (is_p1 | is_p2)
                        begin
                            n_q <= is_p1 ? off1[2:0] : off2[2:0];
                            cs_q <= C_RD;
                        end
                        else if (is_boot)
                        begin
                            // Boot spare words unread
                            cs_q <= C_W1;
                        end
                        // Else in_seq untouched
                    end
                end
                C_RD:
                begin
                    cs_q <= C_CHK;
                end
                C_CHK:
                begin
                    if ((req_rd_data <= `BPC_IDX_MAX) && !port_full)
                    begin
                        cmdq_push_q <= 1'b1;
                        cmdq_port_q <= port_q;
                        cmdq_index_q <= req_rd_data[6:0];
                        added_q <= added_q + 1'b1;
                    end
                    if (i_q == n_q)
                    begin
                        cs_q <= C_W1;
                    end
                    else
                    begin
                        i_q <= i_q + 1'b1;
                        req_rd_addr_q <= req_rd_addr_q + 1'b1;
                        cs_q <= C_RD;
                    end
                end
                C_W1:
                begin
                    rsp_we_q <= 1'b1;
                    rsp_addr_q <= `BPC_W_ID;
                    rsp_data_q <= id_q;
                    cs_q <= C_W2;
                end
                C_W2:
                begin
                    rsp_we_q <= 1'b1;
                    rsp_addr_q <= `BPC_W_CNT;
                    rsp_data_q <= {13'h0000, added_q};
                    cs_q <= C_SEQ;
                end
                C_SEQ:
                begin
                    // Seq last, after whole answer
                    in_seq_q <= last_seq_q + 1'b1;
                    warm_boot_q <= boot_q & (id_q == `BPC_ID_WARM);
                    cold_boot_q <= boot_q & (id_q == `BPC_ID_COLD);
                    cs_q <= C_IDLE;
                end
                default:
                begin
                    cs_q <= C_IDLE;
                end
            endcase
        end
    end

    // Two independent pass-thru ports
    bpc_pt_port #(.HREG_WORDS(HREG_WORDS)) u_p1 (
        .core_clk(core_clk), .rst(rst), .mode(p1_type),
        .hdr_valid(p1_hdr_valid), .hdr_ready_q(p1_hdr_ready_q),
        .func(p1_func), .addr(p1_addr), .count(p1_count),
        .wd_valid(p1_wd_valid), .wd_ready_q(p1_wd_ready_q), .wd(p1_wd),
        .rsp_valid_q(p1_rsp_valid_q), .rsp_exc_q(p1_rsp_exc_q),
        .lock_req(lock[0]), .grant(owner_q[0]),
        .push_valid(pvalid[0]), .push_data(pdata1), .push_ready(fifo_in_ready)
    );
    bpc_pt_port #(.HREG_WORDS(HREG_WORDS)) u_p2 (
        .core_clk(core_clk), .rst(rst), .mode(p2_type),
        .hdr_valid(p2_hdr_valid), .hdr_ready_q(p2_hdr_ready_q),
        .func(p2_func), .addr(p2_addr), .count(p2_count),
        .wd_valid(p2_wd_valid), .wd_ready_q(p2_wd_ready_q), .wd(p2_wd),
        .rsp_valid_q(p2_rsp_valid_q), .rsp_exc_q(p2_rsp_exc_q),
        .lock_req(lock[1]), .grant(owner_q[1]),
        .push_valid(pvalid[1]), .push_data(pdata2), .push_ready(fifo_in_ready)
    );

    // Owned per request; writes never mix
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            owner_q <= 2'b00;
        end
        else if ((owner_q & lock) == 2'b00)
        begin
            // Port 1 wins ties; requests are short
            owner_q <= lock[0] ? 2'b01 : (lock[1] ? 2'b10 : 2'b00);
        end
    end

    assign fifo_in_valid = |(pvalid & owner_q);
    assign fifo_in_data = owner_q[1] ? pdata2 : pdata1;
    assign fifo_out_ready = bp_ready;

    bpc_fifo #(.WIDTH(33), .DEPTH(FIFO_DEPTH), .AW(3)) u_fifo (
        .core_clk(core_clk), .rst(rst),
        .in_valid(fifo_in_valid), .in_ready(fifo_in_ready), .in_data(fifo_in_data),
        .out_valid(fifo_out_valid), .out_ready(fifo_out_ready), .out_data(fifo_out_data)
    );

    // Backplane write strobe, one word per pop
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            bp_we_q <= 1'b0;
            bp_addr_q <= 17'h00000;
            bp_data_q <= 16'h0000;
        end
        else
        begin
            bp_we_q <= fifo_out_valid & bp_ready;
            if (fifo_out_valid & bp_ready)
            begin
                bp_addr_q <= fifo_out_data[32:16];
                bp_data_q <= fifo_out_data[15:0];
            end
        end
    end
endmodule // bpc_top
`default_nettype wire

// file: bpc_checker.sv
// Purpose: Port assertions for bpc_top
// Assumes: One clock, async high reset
// Notes: Bound after the module
`timescale 1ns/1ps
`default_nettype none
module bpc_checker (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [15:0] out_seq,
    input wire logic [15:0] in_seq_q,
    input wire logic rsp_we_q,
    input wire logic [5:0] rsp_addr_q,
    input wire logic [15:0] rsp_data_q,
    input wire logic cmdq_push_q,
    input wire logic [6:0] cmdq_index_q,
    input wire logic warm_boot_q,
    input wire logic cold_boot_q,
    input wire logic [2:0] p1_type,
    input wire logic p1_hdr_valid,
    input wire logic p1_hdr_ready_q,
    input wire logic [7:0] p1_func,
    input wire logic p1_rsp_valid_q,
    input wire logic [7:0] p1_rsp_exc_q,
    input wire logic bp_we_q,
    input wire logic [16:0] bp_addr_q
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    idx_range_a: assert property (cmdq_push_q |-> cmdq_index_q <= 7'h63)
        else $error("index high");
    seq_bump_a: assert property (rsp_we_q && rsp_addr_q == 6'h02 |=> in_seq_q == $past(out_seq) + 16'h0001)
        else $error("seq not bumped");
    cnt_follow_a: assert property (rsp_we_q && rsp_addr_q == 6'h01 |=> rsp_we_q && rsp_addr_q == 6'h02)
        else $error("count word missing");
    id_echo_a: assert property (rsp_we_q && rsp_addr_q == 6'h01 |->
        rsp_data_q inside {[16'h1389:16'h138e], [16'h13ed:16'h13f2], 16'h270e, 16'h270f})
        else $error("bad id answered");
    cnt_max_a: assert property (rsp_we_q && rsp_addr_q == 6'h02 |-> rsp_data_q <= 16'h0006)
        else $error("count above six");
    warm_pulse_a: assert property (warm_boot_q |-> $past(rsp_we_q) && $past(rsp_data_q) == 16'h0000
        && in_seq_q == out_seq + 16'h0001)
        else $error("warm misplaced");
    cold_pulse_a: assert property (cold_boot_q |-> !warm_boot_q && in_seq_q == out_seq + 16'h0001)
        else $error("cold misplaced");
    hreg_base_a: assert property (bp_we_q |-> bp_addr_q >= 17'h09c41)
        else $error("write below base");
    bad_func_a: assert property (p1_hdr_valid && p1_hdr_ready_q && p1_func == 8'h03 |->
        ##1 p1_rsp_valid_q && p1_rsp_exc_q == 8'h01)
        else $error("bad func taken");
    type_gate_a: assert property ($past(p1_type, 2) == 3'h0 && $past(p1_type) == 3'h0 |-> !p1_hdr_ready_q)
        else $error("master took header");
endmodule // bpc_checker
bind bpc_top bpc_checker bpc_checker_i (.core_clk, .rst, .out_seq, .in_seq_q, .rsp_we_q, .rsp_addr_q,
    .rsp_data_q, .cmdq_push_q, .cmdq_index_q, .warm_boot_q, .cold_boot_q, .p1_type, .p1_hdr_valid,
    .p1_hdr_ready_q, .p1_func, .p1_rsp_valid_q, .p1_rsp_exc_q, .bp_we_q, .bp_addr_q);
`default_nettype wire

// file: bpc_proc_model.sv
// Purpose: Processor memory behind the backplane
// Assumes: Bench fills req before seq
// Notes: Holding area mirrored for 1024 words only
`timescale 1ns/1ps
`default_nettype none
module bpc_proc_model (
    input wire logic core_clk,
    input wire logic stall,
    input wire logic [5:0] req_rd_addr_q,
    output logic [15:0] req_rd_data,
    input wire logic bp_we_q,
    input wire logic [16:0] bp_addr_q,
    input wire logic [15:0] bp_data_q,
    output logic bp_ready
);
    logic [15:0] req [0:63];
    logic [15:0] hreg [0:1023] = '{default: 16'h0000};
    logic [16:0] off;
    int nw = 0;
    assign req_rd_data = req[req_rd_addr_q];
    // Stall holds ready low
    assign bp_ready = !stall;
    // Holding word k sits at base plus k
    always @(posedge core_clk)
    begin
        off = bp_addr_q - 17'h09c41;
        if (bp_we_q === 1'b1)
        begin
            hreg[off[9:0]] <= bp_data_q;
            nw++;
        end
    end
endmodule // bpc_proc_model
`default_nettype wire

// file: bpc_top_tb.sv
// Purpose: Self-checking bench for bpc_top
// Assumes: Inputs change on the falling edge
// Notes: Both ports driven through shared arrays
`timescale 1ns/1ps
`default_nettype none
module bpc_top_tb;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] out_seq = 16'h0000;
    logic [15:0] req_id = 16'h0000;
    logic full1 = 1'b0, full2 = 1'b0, stall = 1'b0;
    logic [2:0] ty [2] = '{3'h0, 3'h1};
    logic [1:0] hv = 2'b00, wv = 2'b00;
    logic [7:0] fn [2] = '{8'h06, 8'h06};
    logic [15:0] ad [2] = '{16'h0000, 16'h0000}, wd [2] = '{16'h0000, 16'h0000};
    logic [10:0] ct [2] = '{11'h001, 11'h001};
    wire [1:0] hr, wr, rv;
    wire [7:0] ex [2];
    wire [5:0] ra, wa;
    wire [15:0] rd, in_seq, wdat, bpd;
    wire we, push, pport, warm, cold, bpwe, bprdy;
    wire [6:0] pidx;
    wire [16:0] bpa;
    logic [15:0] rlog [0:63];
    logic [7:0] pq [$];
    int nrsp = 0, nwarm = 0, ncold = 0, err_total = 0, compares = 0, cyc = 0;
    bpc_top bpc_top_i (.core_clk(core_clk), .rst(rst), .out_seq(out_seq), .req_id(req_id),
        .req_rd_addr_q(ra), .req_rd_data(rd), .in_seq_q(in_seq), .rsp_we_q(we), .rsp_addr_q(wa),
        .rsp_data_q(wdat), .cmdq_push_q(push), .cmdq_port_q(pport), .cmdq_index_q(pidx),
        .cmdq_full_p1(full1), .cmdq_full_p2(full2), .warm_boot_q(warm), .cold_boot_q(cold),
        .p1_type(ty[0]), .p1_hdr_valid(hv[0]), .p1_hdr_ready_q(hr[0]), .p1_func(fn[0]), .p1_addr(ad[0]),
        .p1_count(ct[0]), .p1_wd_valid(wv[0]), .p1_wd_ready_q(wr[0]), .p1_wd(wd[0]),
        .p1_rsp_valid_q(rv[0]), .p1_rsp_exc_q(ex[0]), .p2_type(ty[1]), .p2_hdr_valid(hv[1]),
        .p2_hdr_ready_q(hr[1]), .p2_func(fn[1]), .p2_addr(ad[1]), .p2_count(ct[1]), .p2_wd_valid(wv[1]),
        .p2_wd_ready_q(wr[1]), .p2_wd(wd[1]), .p2_rsp_valid_q(rv[1]), .p2_rsp_exc_q(ex[1]),
        .bp_we_q(bpwe), .bp_addr_q(bpa), .bp_data_q(bpd), .bp_ready(bprdy));
    bpc_proc_model bpc_proc_model_i (.core_clk(core_clk), .stall(stall), .req_rd_addr_q(ra),
        .req_rd_data(rd), .bp_we_q(bpwe), .bp_addr_q(bpa), .bp_data_q(bpd), .bp_ready(bprdy));
    initial forever #50 core_clk = ~core_clk;
    // Pulse log and hang guard
    always @(posedge core_clk)
    begin
        cyc++;
        if (we === 1'b1)
        begin
            rlog[wa] = wdat;
            nrsp++;
        end
        if (push === 1'b1)
            pq.push_back({pport, pidx});
        if (warm === 1'b1)
            nwarm++;
        if (cold === 1'b1)
            ncold++;
        if (cyc > 30000)
        begin
            err_total++;
            finish_test();
        end
    end
    task chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e)
        begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Request, then seq; wait seq+1
    task cc(input logic [15:0] id, input logic [15:0] cnt);
        nrsp = 0;
        pq.delete();
        req_id = id;
        @(negedge core_clk);
        out_seq = out_seq + 16'h0001;
        while (in_seq !== out_seq + 16'h0001) @(negedge core_clk);
        @(negedge core_clk);
        chk(rlog[1], id);
        chk(rlog[2], cnt);
        chk(nrsp, 2);
    endtask
    // Write on port p: header, n words, answer
    task automatic pt(input int p, input logic [7:0] f, input logic [15:0] a, input logic [10:0] c,
        input int n, input logic [15:0] b, input logic [7:0] e);
        fn[p] = f;
        ad[p] = a;
        ct[p] = c;
        hv[p] = 1'b1;
        while (!hr[p]) @(negedge core_clk);
        @(negedge core_clk);
        hv[p] = 1'b0;
        for (int k = 0; k < n; k++)
        begin
            wd[p] = b + k[15:0];
            wv[p] = 1'b1;
            while (!wr[p]) @(negedge core_clk);
            @(negedge core_clk);
        end
        wv[p] = 1'b0;
        while (!rv[p]) @(negedge core_clk);
        chk(ex[p], e);
        @(negedge core_clk);
    endtask
    task drain(input int n);
        while (bpc_proc_model_i.nw < n) @(negedge core_clk);
    endtask
    task t_cmd();
        bpc_proc_model_i.req[2] = 16'h0005;
        bpc_proc_model_i.req[3] = 16'h0063;
        bpc_proc_model_i.req[4] = 16'h0064;
        cc(16'h138b, 16'h0002);
        chk(pq.size(), 2);
        chk(pq[1], 8'h63);
        full2 = 1'b1;
        cc(16'h13ee, 16'h0000);
        full2 = 1'b0;
        cc(16'h13ed, 16'h0001);
        chk(pq[0], 8'h85);
    endtask
    task t_boot();
        cc(16'h270e, 16'h0000);
        chk(nwarm, 1);
        cc(16'h270f, 16'h0000);
        chk(ncold, 1);
    endtask
    // Unknown id: no words, sequence left alone
    task t_unknown();
        nrsp = 0;
        req_id = 16'h04d2;
        @(negedge core_clk);
        out_seq = out_seq + 16'h0001;
        repeat (20) @(negedge core_clk);
        chk(in_seq, out_seq);
        chk(nrsp, 0);
    endtask
    task t_pt_err();
        ty[0] = 3'h4;
        ty[1] = 3'h5;
        repeat (2) @(negedge core_clk);
        pt(0, 8'h03, 16'h0000, 11'h001, 0, 16'h0000, 8'h01);
        pt(0, 8'h0f, 16'h0000, 11'h321, 0, 16'h0000, 8'h03);
        pt(0, 8'h10, 16'h0000, 11'h07e, 0, 16'h0000, 8'h03);
        pt(0, 8'h10, 16'h270f, 11'h002, 0, 16'h0000, 8'h02);
    endtask
    // Both ports at once, then the 125 word limit
    task t_pt_data();
        fork
            pt(0, 8'h10, 16'h01f4, 11'h003, 3, 16'h1234, 8'h00);
            pt(1, 8'h06, 16'h000a, 11'h001, 1, 16'habcd, 8'h00);
        join
        drain(4);
        chk(bpc_proc_model_i.hreg[502], 16'h1236);
        chk(bpc_proc_model_i.hreg[10], 16'hcdab);
        pt(0, 8'h10, 16'h0000, 11'h07d, 125, 16'h0100, 8'h00);
        drain(129);
        chk(bpc_proc_model_i.hreg[124], 16'h017c);
    endtask
    // Stalled path fills queue; next is busy
    task t_busy();
        stall = 1'b1;
        pt(0, 8'h10, 16'h0200, 11'h008, 8, 16'h5000, 8'h00);
        pt(1, 8'h06, 16'h0210, 11'h001, 1, 16'h6000, 8'h06);
        stall = 1'b0;
        drain(137);
        repeat (10) @(negedge core_clk);
        chk(bpc_proc_model_i.nw, 137);
        chk(bpc_proc_model_i.hreg[16'h0207], 16'h5007);
        chk(bpc_proc_model_i.hreg[16'h0210], 16'h0000);
    endtask
    task finish_test();
        $display("errors=%0d compares=%0d", err_total, compares);
        if (err_total == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(negedge core_clk);
        rst = 1'b0;
        @(negedge core_clk);
        t_cmd();
        t_boot();
        t_unknown();
        t_pt_err();
        t_pt_data();
        t_busy();
        finish_test();
    end
endmodule // bpc_top_tb
`default_nettype wire
